/* flag_keep.v */
// Sticky status flag: hardware sets it, a clear request drops it.
// Assumes set and clear are synchronous to clk_in.
`timescale 1ns/10ps
module flag_keep (
    // Clock, reset, enable
    input  wire clk_in,
    input  wire resetn_in,
    input  wire ce_in,
    // Control
    input  wire set_in,
    input  wire clr_in,
    // State
    output reg  flag_out
);

    // A set arriving with a clear wins, so no event is lost
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            flag_out <= 1'b0;
        end else if (ce_in) begin
            if (set_in) begin
                flag_out <= 1'b1;
            end else if (clr_in) begin
                flag_out <= 1'b0;
            end
        end
    end

endmodule

/* spi_far_end.sv */
// Far-side model: drives the port-side levels and one-cycle event pulses.
// Assumes its tasks are called from one thread, clocked by clk_in.
`timescale 1ns/10ps
module spi_far_end (
    input  wire        clk_in,
    output reg  [4:0]  rx_fill_out = 5'h00,
    output reg  [4:0]  tx_fill_out = 5'h00,
    output reg  [4:0]  rd_idx_out  = 5'h00,
    output reg  [4:0]  wr_idx_out  = 5'h00,
    output reg         busy_out    = 1'b0,
    output reg         sh_out      = 1'b0,
    output reg         ferr_out    = 1'b0,
    output reg         starve_out  = 1'b0,
    output reg         done_out    = 1'b0,
    output reg  [31:0] word_out    = 32'h00000000
);
    task set_levels(input [4:0] r, input [4:0] t, input [4:0] ri, input [4:0] wi,
                    input a, input s);
        begin
            @(posedge clk_in);
            rx_fill_out <= r;
            tx_fill_out <= t;
            rd_idx_out  <= ri;
            wr_idx_out  <= wi;
            busy_out    <= a;
            sh_out      <= s;
        end
    endtask

    task pulse(input [1:0] k, input [31:0] d);
        begin
            @(posedge clk_in);
            ferr_out   <= (k == 2'h0);
            starve_out <= (k == 2'h1);
            done_out   <= (k == 2'h2);
            word_out   <= d;
            @(posedge clk_in);
            ferr_out   <= 1'b0;
            starve_out <= 1'b0;
            done_out   <= 1'b0;
            // Word lines no longer valid: show the inverse, never a held copy
            word_out   <= ~d;
        end
    endtask
endmodule

/* spi_status_checker_props.sv */
// Assertion checker for the serial port status word.
// Assumes it sees only the top module ports, through the bind below.
`timescale 1ns/10ps
module spi_status_checker #(
    parameter ADDR_W = 8,
    parameter CNT_W  = 5,
    parameter IDX_W  = 5
) (
    input wire              clk_in,
    input wire              resetn_in,
    input wire [ADDR_W-1:0] s_axi_araddr_in,
    input wire              s_axi_arvalid_in,
    input wire              s_axi_arready_out,
    input wire [31:0]       s_axi_rdata_out,
    input wire              s_axi_rvalid_out,
    input wire [CNT_W-1:0]  rx_fill_count_in,
    input wire [CNT_W-1:0]  tx_fill_count_in,
    input wire              activity_flag_in,
    input wire              shifter_empty_in,
    input wire [IDX_W-1:0]  rx_read_index_in,
    input wire [IDX_W-1:0]  rx_write_index_in,
    input wire              module_enable_out,
    input wire              deep_buffer_mode_out
);
    reg             st_reg;
    reg             en_reg;
    reg             deep_reg;
    reg             act_reg;
    reg             sh_reg;
    reg             eq_reg;
    reg             off_reg;
    reg [CNT_W-1:0] rx_reg;
    reg [CNT_W-1:0] tx_reg;
    wire            take = s_axi_arvalid_in && s_axi_arready_out;

    // Snapshot what the status word must show at the moment a read is taken
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_reg <= 1'b0;
            en_reg <= 1'b0;
        end else begin
            en_reg <= module_enable_out;
            if (take)
                st_reg <= (s_axi_araddr_in == 'h0);
        end
    end

    always @(posedge clk_in) begin
        if (take) begin
            deep_reg <= deep_buffer_mode_out;
            act_reg  <= activity_flag_in;
            sh_reg   <= shifter_empty_in;
            eq_reg   <= (rx_read_index_in == rx_write_index_in);
            off_reg  <= !en_reg;
            rx_reg   <= rx_fill_count_in;
            tx_reg   <= tx_fill_count_in;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    sequence s_ans;
        s_axi_rvalid_out && st_reg;
    endsequence
    sequence s_deep_ans;
        s_ans ##0 deep_reg;
    endsequence

    property p_rx_fill;
        s_deep_ans |-> s_axi_rdata_out[28:24] == rx_reg;
    endproperty
    property p_tx_fill;
        s_deep_ans |-> s_axi_rdata_out[20:16] == tx_reg;
    endproperty
    property p_shifter;
        s_deep_ans |-> s_axi_rdata_out[7] == sh_reg;
    endproperty
    property p_empty;
        s_deep_ans |-> s_axi_rdata_out[5] == eq_reg;
    endproperty
    property p_activity;
        s_ans |-> s_axi_rdata_out[11] == act_reg;
    endproperty
    property p_zeros;
        s_ans |-> {s_axi_rdata_out[31:29], s_axi_rdata_out[23:21], s_axi_rdata_out[15:13],
                   s_axi_rdata_out[10:9], s_axi_rdata_out[4]} == 12'h000;
    endproperty
    property p_deep_off;
        s_ans ##0 !deep_reg |-> s_axi_rdata_out[28:16] == 13'h0000 && s_axi_rdata_out[7:5] != 3'h5
            && !s_axi_rdata_out[7] && !s_axi_rdata_out[5];
    endproperty
    property p_und_off;
        s_ans ##0 off_reg |-> !s_axi_rdata_out[8];
    endproperty

    a_rx_fill:  assert property (p_rx_fill)  else $error("rx fill count wrong");
    a_tx_fill:  assert property (p_tx_fill)  else $error("tx fill count wrong");
    a_shifter:  assert property (p_shifter)  else $error("shifter empty wrong");
    a_empty:    assert property (p_empty)    else $error("rx queue empty wrong");
    a_activity: assert property (p_activity) else $error("activity flag wrong");
    a_zeros:    assert property (p_zeros)    else $error("unused bit set");
    a_deep_off: assert property (p_deep_off) else $error("deep fields not zero");
    a_und_off:  assert property (p_und_off)  else $error("underrun while off");
endmodule

bind spi_status_reporting spi_status_checker #(
    .ADDR_W(ADDR_W),
    .CNT_W (CNT_W),
    .IDX_W (IDX_W)
) checker_i (.*);

/* spi_status_defs.vh */
// Constants for the serial port status block: offsets, field positions,
// reset values and AXI4-Lite response codes.
// Assumes inclusion by bare name from the design files.
`ifndef SPI_STATUS_DEFS_VH
`define SPI_STATUS_DEFS_VH

// Register byte offsets
`define OFF_STATUS        8'h00
`define OFF_CONTROL       8'h04
`define OFF_DATA_WINDOW   8'h08

// Status word field positions
`define ST_RX_FILL_LSB    24
`define ST_RX_FILL_MSB    28
`define ST_TX_FILL_LSB    16
`define ST_TX_FILL_MSB    20
`define ST_FRAME_FAULT    12
`define ST_ACTIVITY       11
`define ST_TX_UNDERRUN    8
`define ST_SHIFTER_EMPTY  7
`define ST_RX_OVERFLOW    6
`define ST_RX_Q_EMPTY     5

// Control register field positions
`define CT_MODULE_ENABLE  0
`define CT_DEEP_BUFFER    1
`define CT_FRAMED_ENABLE  2
`define CT_FRAMED_SYNC    3
`define CT_WIDTH          4

// Reset values
`define CONTROL_RESET     4'h0
`define DATA_RESET        32'h00000000

// AXI4-Lite responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

/* spi_status_reporting.v */
// Status reporting of a serial port, reached over an AXI4-Lite slave.
// Assumes port-side events and levels are synchronous to clk_in.
// Function
// - Report receive queue fill count in bits 28..24, deep-buffer mode only.
// - Report transmit queue fill count in bits 20..16, deep-buffer mode only.
// - Set frame fault at bit 12 on frame error while framed mode enabled.
// - Bit 11 shows high while the port is busy, low when idle.
// - Set transmit underrun at bit 8 on underrun in framed sync mode.
// - Underrun stays set until module enable is cycled, writes cannot clear it.
// - Bit 7 shows shift register empty, valid in deep-buffer mode.
// - Set receive overflow at bit 6 when new word discarded over unread word.
// - Overflow set only by hardware; writing zero clears, writing one does nothing.
// - Bit 5 high exactly when receive read index equals write index, deep-buffer mode only.
// - Bits 31..29, 23..21, 15..13, 10..9 and 4 read zero.
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "spi_status_defs.vh"
module spi_status_reporting #(
    parameter ADDR_W = 8,
    parameter CNT_W  = 5,
    parameter IDX_W  = 5
) (
    // Clock, reset, enable
    input  wire              clk_in,
    input  wire              resetn_in,
    input  wire              ce_in,
    // AXI4-Lite write address
    input  wire [ADDR_W-1:0] s_axi_awaddr_in,
    input  wire              s_axi_awvalid_in,
    output reg               s_axi_awready_out,
    // AXI4-Lite write data
    input  wire [31:0]       s_axi_wdata_in,
    input  wire [3:0]        s_axi_wstrb_in,
    input  wire              s_axi_wvalid_in,
    output reg               s_axi_wready_out,
    // AXI4-Lite write response
    output reg  [1:0]        s_axi_bresp_out,
    output reg               s_axi_bvalid_out,
    input  wire              s_axi_bready_in,
    // AXI4-Lite read address
    input  wire [ADDR_W-1:0] s_axi_araddr_in,
    input  wire              s_axi_arvalid_in,
    output reg               s_axi_arready_out,
    // AXI4-Lite read data
    output reg  [31:0]       s_axi_rdata_out,
    output reg  [1:0]        s_axi_rresp_out,
    output reg               s_axi_rvalid_out,
    input  wire              s_axi_rready_in,
    // Port-side levels
    input  wire [CNT_W-1:0]  rx_fill_count_in,
    input  wire [CNT_W-1:0]  tx_fill_count_in,
    input  wire              activity_flag_in,
    input  wire              shifter_empty_in,
    input  wire [IDX_W-1:0]  rx_read_index_in,
    input  wire [IDX_W-1:0]  rx_write_index_in,
    // Port-side event pulses
    input  wire              frame_error_in,
    input  wire              tx_starved_in,
    input  wire              rx_word_done_in,
    input  wire [31:0]       rx_word_in,
    // Mode outputs to the rest of the port
    output reg               module_enable_out,
    output reg               deep_buffer_mode_out,
    output reg               framed_mode_enable_out,
    output reg               framed_sync_out
);

    localparam NFLAG = 3;
    localparam FL_FRAME = 0;
    localparam FL_UNDER = 1;
    localparam FL_ROV   = 2;

    // Returns one-hot {data_window, control, status}, zero when unmapped
    function [2:0] reg_sel;
        input [ADDR_W-1:0] addr;
        begin
            if (addr == `OFF_STATUS) begin
                reg_sel = 3'h1;
            end else if (addr == `OFF_CONTROL) begin
                reg_sel = 3'h2;
            end else if (addr == `OFF_DATA_WINDOW) begin
                reg_sel = 3'h4;
            end else begin
                reg_sel = 3'h0;
            end
        end
    endfunction

    // Write channel holding registers
    reg                 aw_held_reg;
    reg [ADDR_W-1:0]    aw_addr_reg;
    reg                 w_held_reg;
    reg [31:0]          w_data_reg;
    reg [3:0]           w_strb_reg;

    // Port state
    reg [31:0]          data_window_reg;
    reg                 unread_reg;
    reg                 enable_prev_reg;

    wire [NFLAG-1:0]    flag_set;
    wire [NFLAG-1:0]    flag_clr;
    wire [NFLAG-1:0]    flag_state;
    wire [31:0]         status_word;

    wire                aw_take;
    wire                w_take;
    wire                do_write;
    wire                ar_take;
    wire [2:0]          wr_sel;
    wire [2:0]          rd_sel;
    wire                st_write;
    wire                data_read;
    wire                word_lost;

    assign aw_take   = s_axi_awvalid_in & s_axi_awready_out;
    assign w_take    = s_axi_wvalid_in & s_axi_wready_out;
    assign do_write  = aw_held_reg & w_held_reg & ~s_axi_bvalid_out;
    assign ar_take   = s_axi_arvalid_in & s_axi_arready_out;
    assign wr_sel    = reg_sel(aw_addr_reg);
    assign rd_sel    = reg_sel(s_axi_araddr_in);
    assign st_write  = do_write & wr_sel[0];
    assign data_read = ar_take & rd_sel[2];

    // A word finishing while the window still holds an unread one is
    // dropped; a read in the same cycle frees the window first
    assign word_lost = rx_word_done_in & unread_reg & ~data_read;

    // Frame fault counts only in framed mode
    assign flag_set[FL_FRAME] = frame_error_in & framed_mode_enable_out;
    // Underrun counts only in framed sync mode with the module on
    assign flag_set[FL_UNDER] = tx_starved_in & framed_mode_enable_out
                                & framed_sync_out & module_enable_out;
    assign flag_set[FL_ROV]   = word_lost;

    // Frame fault and overflow clear on a write of zero to their bit
    assign flag_clr[FL_FRAME] = st_write & w_strb_reg[1]
                                & ~w_data_reg[`ST_FRAME_FAULT];
    assign flag_clr[FL_ROV]   = st_write & w_strb_reg[0]
                                & ~w_data_reg[`ST_RX_OVERFLOW];
    // Underrun ignores writes and clears only while the module is off
    assign flag_clr[FL_UNDER] = ~module_enable_out;

    genvar gi;
    generate
        for (gi = 0; gi < NFLAG; gi = gi + 1) begin : g_flag
            flag_keep u_flag (
                .clk_in    (clk_in),
                .resetn_in (resetn_in),
                .ce_in     (ce_in),
                .set_in    (flag_set[gi]),
                .clr_in    (flag_clr[gi]),
                .flag_out  (flag_state[gi])
            );
        end
    endgenerate

    status_pack #(
        .CNT_W (CNT_W),
        .IDX_W (IDX_W)
    ) u_pack (
        .deep_buffer_in    (deep_buffer_mode_out),
        .rx_fill_in        (rx_fill_count_in),
        .tx_fill_in        (tx_fill_count_in),
        .activity_in       (activity_flag_in),
        .shifter_empty_in  (shifter_empty_in),
        .rx_read_index_in  (rx_read_index_in),
        .rx_write_index_in (rx_write_index_in),
        .frame_fault_in    (flag_state[FL_FRAME]),
        .tx_underrun_in    (flag_state[FL_UNDER]),
        .rx_overflow_in    (flag_state[FL_ROV]),
        .word_out          (status_word)
    );

    // Write address and data are taken independently, in either order
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            aw_held_reg       <= 1'b0;
            aw_addr_reg       <= {ADDR_W{1'b0}};
            w_held_reg        <= 1'b0;
            w_data_reg        <= 32'h00000000;
            w_strb_reg        <= 4'h0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out  <= 1'b1;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= `RESP_OKAY;
        end else if (ce_in) begin
            if (aw_take) begin
                aw_held_reg       <= 1'b1;
                aw_addr_reg       <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end
            if (w_take) begin
                w_held_reg       <= 1'b1;
                w_data_reg       <= s_axi_wdata_in;
                w_strb_reg       <= s_axi_wstrb_in;
                s_axi_wready_out <= 1'b0;
            end
            if (do_write) begin
                aw_held_reg      <= 1'b0;
                w_held_reg       <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                if (wr_sel == 3'h0) begin
                    s_axi_bresp_out <= `RESP_SLVERR;
                end else begin
                    s_axi_bresp_out <= `RESP_OKAY;
                end
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                // Ready reopens only after the response, one write at a time
                s_axi_bvalid_out  <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out  <= 1'b1;
            end
        end
    end

    // Control register; writes to the data window are ignored
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            module_enable_out      <= 1'b0;
            deep_buffer_mode_out   <= 1'b0;
            framed_mode_enable_out <= 1'b0;
            framed_sync_out        <= 1'b0;
        end else if (ce_in) begin
            if (do_write && wr_sel[1] && w_strb_reg[0]) begin
                module_enable_out      <= w_data_reg[`CT_MODULE_ENABLE];
                deep_buffer_mode_out   <= w_data_reg[`CT_DEEP_BUFFER];
                framed_mode_enable_out <= w_data_reg[`CT_FRAMED_ENABLE];
                framed_sync_out        <= w_data_reg[`CT_FRAMED_SYNC];
            end
        end
    end

    // Receive data window with its unread marker
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            data_window_reg <= `DATA_RESET;
            unread_reg      <= 1'b0;
            enable_prev_reg <= 1'b0;
        end else if (ce_in) begin
            enable_prev_reg <= module_enable_out;
            if (rx_word_done_in && !word_lost) begin
                data_window_reg <= rx_word_in;
                unread_reg      <= 1'b1;
            end else if (data_read) begin
                unread_reg <= 1'b0;
            end else if (enable_prev_reg && !module_enable_out) begin
                // Turning the module off abandons any pending word
                unread_reg <= 1'b0;
            end
        end
    end

    // Read channel: data is registered, so status is sampled at the
    // address handshake, not when rready arrives
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h00000000;
            s_axi_rresp_out   <= `RESP_OKAY;
        end else if (ce_in) begin
            if (ar_take) begin
                s_axi_arready_out <= 1'b0;
                s_axi_rvalid_out  <= 1'b1;
                s_axi_rresp_out   <= `RESP_OKAY;
                if (rd_sel[0]) begin
                    s_axi_rdata_out <= status_word;
                end else if (rd_sel[1]) begin
                    s_axi_rdata_out <= {{(32-`CT_WIDTH){1'b0}}, framed_sync_out,
                                        framed_mode_enable_out, deep_buffer_mode_out,
                                        module_enable_out};
                end else if (rd_sel[2]) begin
                    s_axi_rdata_out <= data_window_reg;
                end else begin
                    s_axi_rdata_out <= 32'h00000000;
                    s_axi_rresp_out <= `RESP_SLVERR;
                end
            end else if (s_axi_rvalid_out && s_axi_rready_in) begin
                s_axi_rvalid_out  <= 1'b0;
                s_axi_arready_out <= 1'b1;
            end
        end
    end

endmodule

/* spi_status_reporting_test.sv */
// Self-checking bench for the status block with a behavioural model.
// Assumes spi_far_end drives the port side and the checker is bound.
`timescale 1ns/10ps
module spi_status_reporting_test;
    reg         clk_in = 1'b0, resetn_in = 1'b0;
    reg  [7:0]  awaddr = 8'h00, araddr = 8'h00, seed = 8'h5A;
    reg  [31:0] wdata = 32'h00000000, got, m_word;
    reg  [3:0]  wstrb = 4'h0, m_ctrl = 4'h0;
    reg         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    reg         m_frm = 0, m_und = 0, m_ovf = 0, m_unread = 0, l_act = 0, l_sh = 0;
    reg         ce = 1'b1;
    wire        men, dbm, fme, fso;
    reg  [4:0]  l_rx = 0, l_tx = 0, l_ri = 0, l_wi = 0;
    reg  [1:0]  gresp;
    wire        awready, wready, bvalid, arready, rvalid, act, she, ferr, stv, done;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata, rword;
    wire [4:0]  rxf, txf, ri, wi;
    integer     mismatches = 0, comparisons = 0, i, n;

    always #25 clk_in = ~clk_in;

    spi_far_end spi_far_end_i (.clk_in(clk_in), .rx_fill_out(rxf), .tx_fill_out(txf),
        .rd_idx_out(ri), .wr_idx_out(wi), .busy_out(act), .sh_out(she), .ferr_out(ferr),
        .starve_out(stv), .done_out(done), .word_out(rword));

    spi_status_reporting spi_status_reporting_i (.clk_in(clk_in), .resetn_in(resetn_in),
        .ce_in(ce), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .rx_fill_count_in(rxf), .tx_fill_count_in(txf), .activity_flag_in(act),
        .shifter_empty_in(she), .rx_read_index_in(ri), .rx_write_index_in(wi),
        .frame_error_in(ferr), .tx_starved_in(stv), .rx_word_done_in(done),
        .rx_word_in(rword), .module_enable_out(men), .deep_buffer_mode_out(dbm),
        .framed_mode_enable_out(fme), .framed_sync_out(fso));

    function [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic [31:0] exp_st();
        exp_st = 32'h00000000;
        if (m_ctrl[1]) begin
            exp_st[28:24] = l_rx;
            exp_st[20:16] = l_tx;
            exp_st[7]     = l_sh;
            exp_st[5]     = (l_ri == l_wi);
        end
        exp_st[12] = m_frm;
        exp_st[11] = l_act;
        exp_st[8]  = m_und;
        exp_st[6]  = m_ovf;
    endfunction

    task stop_test;
        begin
            $display("mismatches %0d comparisons %0d", mismatches, comparisons);
            if (mismatches == 0 && comparisons > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    task chk(input [31:0] seen, input [31:0] exp, input string what);
        begin
            comparisons++;
            if (seen !== exp) begin
                mismatches++;
                $display("BAD %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    task wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
        begin
            @(posedge clk_in);
            awaddr <= a; wdata <= d; wstrb <= s;
            awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
            for (n = 0; n < 100; n++) begin
                @(posedge clk_in);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                if (bvalid) break;
            end
            gresp = bresp;
            bready <= 1'b0;
            if (n == 100) begin mismatches++; stop_test; end
            chk({30'h0, gresp}, {30'h0, er}, "bresp");
        end
    endtask

    task rd(input [7:0] a, input [31:0] e, input [1:0] er);
        begin
            @(posedge clk_in);
            araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
            for (n = 0; n < 100; n++) begin
                @(posedge clk_in);
                if (arready) arvalid <= 1'b0;
                if (rvalid) break;
            end
            got = rdata;
            gresp = rresp;
            rready <= 1'b0;
            if (n == 100) begin mismatches++; stop_test; end
            chk(got, e, "rdata");
            chk({30'h0, gresp}, {30'h0, er}, "rresp");
        end
    endtask

    task wrc(input [3:0] d);
        begin
            wr(8'h04, {28'h0, d}, 4'hF, 2'h0);
            m_ctrl = d;
            chk({28'h0, fso, fme, dbm, men}, {28'h0, d}, "mode pins");
            if (!d[0]) begin m_und = 0; m_unread = 0; end
        end
    endtask

    task ws(input [31:0] d, input [3:0] s);
        begin
            wr(8'h00, d, s, 2'h0);
            if (s[1] && !d[12]) m_frm = 0;
            if (s[0] && !d[6]) m_ovf = 0;
        end
    endtask

    task ev(input [1:0] k, input [31:0] d);
        begin
            spi_far_end_i.pulse(k, d);
            if (k == 2'h0 && m_ctrl[2]) m_frm = 1;
            if (k == 2'h1 && m_ctrl[0] && m_ctrl[2] && m_ctrl[3]) m_und = 1;
            if (k == 2'h2 && m_unread) m_ovf = 1;
            if (k == 2'h2 && !m_unread) begin m_word = d; m_unread = 1; end
        end
    endtask

    initial begin
        repeat (8) @(posedge clk_in);
        resetn_in <= 1'b1;
        rd(8'h00, exp_st(), 2'h0);
        rd(8'h0C, 32'h00000000, 2'h2);
        wr(8'h10, 32'hFFFFFFFF, 4'hF, 2'h2);
        wrc(4'h3);
        for (i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            l_rx = (i == 0) ? 5'h1F : seed[4:0]; l_tx = seed[7:3];
            l_ri = seed[4:0]; l_wi = i[0] ? seed[4:0] : ~seed[4:0];
            l_act = seed[1]; l_sh = seed[6];
            spi_far_end_i.set_levels(l_rx, l_tx, l_ri, l_wi, l_act, l_sh);
            rd(8'h00, exp_st(), 2'h0);
        end
        wrc(4'h1);
        rd(8'h00, exp_st(), 2'h0);
        ev(2'h0, 32'h0);
        rd(8'h00, exp_st(), 2'h0);
        wrc(4'h5);
        // A frame error while the clock enable is low must leave the flag alone
        ce <= 1'b0;
        spi_far_end_i.pulse(2'h0, 32'h0);
        ce <= 1'b1;
        rd(8'h00, exp_st(), 2'h0);
        ev(2'h0, 32'h0);
        rd(8'h00, exp_st(), 2'h0);
        ws(32'h00000000, 4'h2);
        rd(8'h00, exp_st(), 2'h0);
        wrc(4'hD);
        ev(2'h1, 32'h0);
        rd(8'h00, exp_st(), 2'h0);
        ws(32'h00000000, 4'hF);
        rd(8'h00, exp_st(), 2'h0);
        wrc(4'hC);
        rd(8'h00, exp_st(), 2'h0);
        wrc(4'hD);
        rd(8'h00, exp_st(), 2'h0);
        seed = lfsr(seed);
        ev(2'h2, {4{seed}});
        ev(2'h2, ~{4{seed}});
        rd(8'h00, exp_st(), 2'h0);
        rd(8'h08, m_word, 2'h0);
        m_unread = 0;
        wr(8'h08, 32'hFFFFFFFF, 4'hF, 2'h0);
        rd(8'h08, m_word, 2'h0);
        ws(32'h00000040, 4'hF);
        rd(8'h00, exp_st(), 2'h0);
        ws(32'h00000000, 4'h1);
        rd(8'h00, exp_st(), 2'h0);
        rd(8'h04, {28'h0, m_ctrl}, 2'h0);
        stop_test;
    end
endmodule

/* status_pack.v */
// Assembles the 32-bit port status word from live state and sticky flags.
// Assumes all inputs come from the same clock domain.
`timescale 1ns/10ps
`include "spi_status_defs.vh"
module status_pack #(
    parameter CNT_W = 5,
    parameter IDX_W = 5
) (
    // Mode
    input  wire             deep_buffer_in,
    // Live state
    input  wire [CNT_W-1:0] rx_fill_in,
    input  wire [CNT_W-1:0] tx_fill_in,
    input  wire             activity_in,
    input  wire             shifter_empty_in,
    input  wire [IDX_W-1:0] rx_read_index_in,
    input  wire [IDX_W-1:0] rx_write_index_in,
    // Sticky flags
    input  wire             frame_fault_in,
    input  wire             tx_underrun_in,
    input  wire             rx_overflow_in,
    // Result
    output reg  [31:0]      word_out
);

    always @* begin
        // Unlisted bits stay zero
        word_out = 32'h00000000;
        if (deep_buffer_in) begin
            word_out[`ST_RX_FILL_MSB:`ST_RX_FILL_LSB] = rx_fill_in;
            word_out[`ST_TX_FILL_MSB:`ST_TX_FILL_LSB] = tx_fill_in;
            word_out[`ST_SHIFTER_EMPTY] = shifter_empty_in;
            word_out[`ST_RX_Q_EMPTY] = (rx_read_index_in == rx_write_index_in);
        end
        word_out[`ST_FRAME_FAULT] = frame_fault_in;
        word_out[`ST_ACTIVITY] = activity_in;
        word_out[`ST_TX_UNDERRUN] = tx_underrun_in;
        word_out[`ST_RX_OVERFLOW] = rx_overflow_in;
    end

endmodule
